/* hw/csu_uart.sv */
// Camera serial port: APB registers, transmitter, receiver and FIFOs.
//
// Contract
// - Transmit and receive each have a hardware FIFO of 64 characters.
// - Stop length is one, one and a half or two bit periods.
// - Each character carries five, six, seven or eight data bits.
// - Parity is odd, even or none, added on send and checked on receive.
// - Bit rate is one of the standard rates from 300 to 115200 baud.
// - With flow control on, received XON and XOFF resume and pause sending.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module csu_uart
    import csu_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // APB slave.
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line.
    input wire logic rxd,
    output logic txd
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        csu_ctrl_t ctrl;
        logic [2:0] rx_sync;
        logic rx_line;
        csu_tx_st_t tx_st;
        logic [5:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic txd;
        csu_rx_st_t rx_st;
        logic [5:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        logic rx_perr;
        logic rx_push;
        logic [7:0] rx_byte;
        logic paused;
        logic err_par;
        logic err_frame;
        logic err_ovr;
        logic err_txdrop;
    } csu_state_t;

    csu_state_t s_q, s_d;
    logic tick, acc, done, tx_pop, tx_end, rx_end, odd_par, par_en;
    logic [5:0] tx_lim, rx_lim;
    logic [2:0] last_bit;
    logic [7:0] dmask, rx_word;

    csu_fifo_if #(.W(8), .AW(CSU_FIFO_AW)) tx_f();
    csu_fifo_if #(.W(8), .AW(CSU_FIFO_AW)) rx_f();

    // ****************************************
    // Submodules
    // ****************************************

    // Both queues are 64 deep so software need not serve every character.
    csu_fifo #(.W(8), .DEPTH(CSU_FIFO_DEPTH), .AW(CSU_FIFO_AW)) u_txq (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .f(tx_f.store)
    );
    csu_fifo #(.W(8), .DEPTH(CSU_FIFO_DEPTH), .AW(CSU_FIFO_AW)) u_rxq (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .f(rx_f.store)
    );
    csu_baud u_baud (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .sel(s_q.ctrl.baud),
        .tick(tick)
    );

    // ****************************************
    // Decoded helpers
    // ****************************************

    // Access is answered one cycle into the access phase.
    assign acc = psel & penable & ~s_q.pready;
    assign done = psel & penable & s_q.pready;
    assign par_en = s_q.ctrl.parity != CSU_PAR_NONE;
    assign odd_par = s_q.ctrl.parity == CSU_PAR_ODD;
    assign last_bit = {1'b1, s_q.ctrl.dbits};
    assign dmask = 8'hff >> (2'h3 - s_q.ctrl.dbits);
    assign rx_word = s_q.rx_sh >> (2'h3 - s_q.ctrl.dbits);

    // Tick limits per state; stop codes above two bits count as two.
    always_comb
    begin
        case (s_q.ctrl.stop)
            CSU_STOP_1: tx_lim = CSU_STOP1_LIM;
            CSU_STOP_15: tx_lim = CSU_STOP15_LIM;
            default: tx_lim = CSU_STOP2_LIM;
        endcase
        if (s_q.tx_st != CSU_TX_STOP)
            tx_lim = CSU_BIT_LIM;
        rx_lim = (s_q.rx_st == CSU_RX_START) ? CSU_HALF_LIM : CSU_BIT_LIM;
    end
    assign tx_end = tick & (s_q.tx_cnt == tx_lim);
    assign rx_end = tick & (s_q.rx_cnt == rx_lim);

    // FIFO hand-shakes; a dropped write to a full queue is flagged.
    assign tx_pop = (s_q.tx_st == CSU_TX_IDLE) & tx_f.rd_valid & ~s_q.paused;
    assign tx_f.rd_ready = tx_pop;
    assign tx_f.wr_valid = done & pwrite & (paddr == CSU_ADDR_DATA);
    assign tx_f.wr_data = pwdata[7:0];
    // Only pop what the read actually returned, not a later arrival.
    assign rx_f.rd_ready = done & ~pwrite & (paddr == CSU_ADDR_DATA)
        & s_q.prdata[CSU_DATA_VLD];
    assign rx_f.wr_valid = s_q.rx_push;
    assign rx_f.wr_data = s_q.rx_byte;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        s_d.pready = acc;
        s_d.pslverr = 1'b0;
        s_d.rx_push = 1'b0;

        // Register read data is captured when the answer is raised.
        if (acc & ~pwrite)
        begin
            s_d.prdata = '0;
            case (paddr)
                CSU_ADDR_DATA:
                    s_d.prdata = {23'h0, rx_f.rd_valid, rx_f.rd_data};
                CSU_ADDR_CTRL:
                    s_d.prdata = {21'h0, s_q.ctrl};
                CSU_ADDR_STAT:
                begin
                    s_d.prdata[CSU_ST_RXAV] = rx_f.rd_valid;
                    s_d.prdata[CSU_ST_TXFULL] = ~tx_f.wr_ready;
                    s_d.prdata[CSU_ST_TXEMPTY] = ~tx_f.rd_valid;
                    s_d.prdata[CSU_ST_PAUSED] = s_q.paused;
                    s_d.prdata[CSU_ST_PERR] = s_q.err_par;
                    s_d.prdata[CSU_ST_FERR] = s_q.err_frame;
                    s_d.prdata[CSU_ST_OVR] = s_q.err_ovr;
                    s_d.prdata[CSU_ST_TXDROP] = s_q.err_txdrop;
                    s_d.prdata[CSU_ST_RXLVL +: 7] = rx_f.level;
                    s_d.prdata[CSU_ST_TXLVL +: 7] = tx_f.level;
                end
                default:
                    s_d.pslverr = 1'b1;
            endcase
        end
        else if (acc)
            s_d.pslverr = (paddr != CSU_ADDR_DATA) & (paddr != CSU_ADDR_CTRL)
                & (paddr != CSU_ADDR_STAT);

        // Writes land at the completing edge; clears come before sets.
        if (done & pwrite & (paddr == CSU_ADDR_CTRL))
            s_d.ctrl = pwdata[10:0];
        if (done & pwrite & (paddr == CSU_ADDR_STAT))
        begin
            s_d.err_par = s_q.err_par & ~pwdata[CSU_ST_PERR];
            s_d.err_frame = s_q.err_frame & ~pwdata[CSU_ST_FERR];
            s_d.err_ovr = s_q.err_ovr & ~pwdata[CSU_ST_OVR];
            s_d.err_txdrop = s_q.err_txdrop & ~pwdata[CSU_ST_TXDROP];
        end
        if (tx_f.wr_valid & ~tx_f.wr_ready)
            s_d.err_txdrop = 1'b1;

        // Line input: a level counts once the second and third stage agree.
        s_d.rx_sync = {s_q.rx_sync[1:0], rxd};
        if (s_q.rx_sync[1] == s_q.rx_sync[2])
            s_d.rx_line = s_q.rx_sync[2];

        // Transmitter; line level follows the state one cycle later.
        if (s_q.tx_st != CSU_TX_IDLE && tick)
            s_d.tx_cnt = tx_end ? 6'h00 : s_q.tx_cnt + 6'h01;
        case (s_q.tx_st)
            CSU_TX_IDLE:
            begin
                s_d.txd = 1'b1;
                if (tx_pop)
                begin
                    s_d.tx_sh = tx_f.rd_data & dmask;
                    s_d.tx_par = ^(tx_f.rd_data & dmask) ^ odd_par;
                    s_d.tx_cnt = '0;
                    s_d.tx_st = CSU_TX_START;
                end
            end
            CSU_TX_START:
            begin
                s_d.txd = 1'b0;
                if (tx_end)
                begin
                    s_d.tx_bit = '0;
                    s_d.tx_st = CSU_TX_DATA;
                end
            end
            CSU_TX_DATA:
            begin
                s_d.txd = s_q.tx_sh[0];
                if (tx_end)
                begin
                    s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
                    s_d.tx_bit = s_q.tx_bit + 3'h1;
                    if (s_q.tx_bit == last_bit)
                        s_d.tx_st = par_en ? CSU_TX_PAR : CSU_TX_STOP;
                end
            end
            CSU_TX_PAR:
            begin
                s_d.txd = s_q.tx_par;
                if (tx_end)
                    s_d.tx_st = CSU_TX_STOP;
            end
            CSU_TX_STOP:
            begin
                s_d.txd = 1'b1;
                if (tx_end)
                    s_d.tx_st = CSU_TX_IDLE;
            end
            default:
            begin
                s_d.txd = 1'b1;
                s_d.tx_st = CSU_TX_IDLE;
            end
        endcase

        // Receiver samples mid-bit, timed from the start edge.
        if (s_q.rx_st != CSU_RX_IDLE && tick)
            s_d.rx_cnt = rx_end ? 6'h00 : s_q.rx_cnt + 6'h01;
        case (s_q.rx_st)
            CSU_RX_IDLE:
                if (!s_q.rx_line)
                begin
                    s_d.rx_cnt = '0;
                    s_d.rx_par = 1'b0;
                    s_d.rx_perr = 1'b0;
                    s_d.rx_st = CSU_RX_START;
                end
            CSU_RX_START:
                if (rx_end)
                begin
                    // A glitch shorter than half a bit is not a start.
                    s_d.rx_bit = '0;
                    s_d.rx_st = s_q.rx_line ? CSU_RX_IDLE : CSU_RX_DATA;
                end
            CSU_RX_DATA:
                if (rx_end)
                begin
                    s_d.rx_sh = {s_q.rx_line, s_q.rx_sh[7:1]};
                    s_d.rx_par = s_q.rx_par ^ s_q.rx_line;
                    s_d.rx_bit = s_q.rx_bit + 3'h1;
                    if (s_q.rx_bit == last_bit)
                        s_d.rx_st = par_en ? CSU_RX_PAR : CSU_RX_STOP;
                end
            CSU_RX_PAR:
                if (rx_end)
                begin
                    s_d.rx_perr = s_q.rx_line != (s_q.rx_par ^ odd_par);
                    s_d.rx_st = CSU_RX_STOP;
                end
            CSU_RX_STOP:
                if (rx_end)
                begin
                    // Only the first stop bit is checked, so any length is read.
                    s_d.rx_st = CSU_RX_IDLE;
                    if (!s_q.rx_line)
                        s_d.err_frame = 1'b1;
                    else if (s_q.ctrl.flow_en && rx_word == CSU_XOFF)
                        s_d.paused = 1'b1;
                    else if (s_q.ctrl.flow_en && rx_word == CSU_XON)
                        s_d.paused = 1'b0;
                    else
                    begin
                        if (s_q.rx_perr)
                            s_d.err_par = 1'b1;
                        if (rx_f.wr_ready)
                        begin
                            s_d.rx_push = 1'b1;
                            s_d.rx_byte = rx_word;
                        end
                        else
                            s_d.err_ovr = 1'b1;
                    end
                end
            default:
                s_d.rx_st = CSU_RX_IDLE;
        endcase

        // Turning flow control off must not leave the sender stuck.
        if (!s_q.ctrl.flow_en)
            s_d.paused = 1'b0;
    end

    // ****************************************
    // State register and outputs
    // ****************************************
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.ctrl <= CSU_CTRL_RST;
            s_q.rx_sync <= 3'h7;
            s_q.rx_line <= 1'b1;
            s_q.txd <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign txd = s_q.txd;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_txq_full;
        (tx_f.level == 7'd64) |-> !tx_f.wr_ready && !(tx_f.level > 7'd64);
    endproperty
    a_txq_full: assert property (p_txq_full)
        else $error("Transmit queue accepted more than 64 characters.");

    property p_stop_len;
        (s_q.tx_st == CSU_TX_STOP && tick && s_q.ctrl.stop == CSU_STOP_15)
        |=> (s_q.tx_st == CSU_TX_IDLE) == ($past(s_q.tx_cnt) == 6'd23)
            && s_q.txd;
    endproperty
    a_stop_len: assert property (p_stop_len)
        else $error("Stop of one and a half bits has the wrong length.");

    property p_six_bits;
        (s_q.tx_st == CSU_TX_DATA && tx_end && s_q.ctrl.dbits == 2'h1)
        |=> (s_q.tx_st == CSU_TX_DATA) == ($past(s_q.tx_bit) < 3'd5);
    endproperty
    a_six_bits: assert property (p_six_bits)
        else $error("Six-bit character sent a wrong number of bits.");

    property p_par_slot;
        (s_q.tx_st == CSU_TX_DATA && tx_end && s_q.tx_bit == last_bit)
        |=> (s_q.tx_st == CSU_TX_PAR) == ($past(s_q.ctrl.parity) != 2'h0);
    endproperty
    a_par_slot: assert property (p_par_slot)
        else $error("Parity bit presence does not match the setting.");

    property p_ctrl_write;
        (done && pwrite && paddr == CSU_ADDR_CTRL)
        |=> s_q.ctrl.baud == $past(pwdata[9:6]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Rate select did not take the written value.");

    property p_paused_hold;
        (s_q.paused && s_q.tx_st == CSU_TX_IDLE) |=> s_q.tx_st == CSU_TX_IDLE;
    endproperty
    a_paused_hold: assert property (p_paused_hold)
        else $error("A character started while sending was paused.");

    property p_start_low;
        (s_q.tx_st == CSU_TX_START) ##1 (s_q.tx_st == CSU_TX_START)
        |-> !s_q.txd;
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("Start bit was not low on the line.");

    c_tx_char: cover property (s_q.tx_st == CSU_TX_STOP ##1
        s_q.tx_st == CSU_TX_IDLE);
    c_rx_char: cover property (s_q.rx_push);
    c_paused: cover property ($rose(s_q.paused));
    c_par_err: cover property ($rose(s_q.err_par));
endmodule // csu_uart

/* hw/csu_pkg.sv */
// Shared constants and types of the camera serial port.
package csu_pkg;

    // ****************************************
    // Clock and bit timing
    // ****************************************
    localparam int unsigned CSU_CLK_HZ = 200_000_000;
    localparam int unsigned CSU_OVS = 16; // Ticks per bit period.
    localparam int unsigned CSU_BAUD_RATE [0:9] = '{300, 600, 1200, 2400,
        4800, 9600, 19200, 38400, 57600, 115200};
    localparam logic [3:0] CSU_BAUD_MAX = 4'h9;
    localparam logic [3:0] CSU_BAUD_DEF = 4'h5;

    // Stop length in ticks, minus one, for 1, 1.5 and 2 bits.
    localparam logic [5:0] CSU_STOP1_LIM = 6'h0f;
    localparam logic [5:0] CSU_STOP15_LIM = 6'h17;
    localparam logic [5:0] CSU_STOP2_LIM = 6'h1f;
    localparam logic [5:0] CSU_BIT_LIM = 6'h0f;
    localparam logic [5:0] CSU_HALF_LIM = 6'h07;

    // ****************************************
    // FIFO geometry and flow characters
    // ****************************************
    localparam int CSU_FIFO_DEPTH = 64;
    localparam int CSU_FIFO_AW = 6;
    localparam logic [7:0] CSU_XON = 8'h11;
    localparam logic [7:0] CSU_XOFF = 8'h13;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] CSU_ADDR_DATA = 12'h000;
    localparam logic [11:0] CSU_ADDR_CTRL = 12'h004;
    localparam logic [11:0] CSU_ADDR_STAT = 12'h008;
    localparam int CSU_DATA_VLD = 8;
    localparam int CSU_ST_RXAV = 0;
    localparam int CSU_ST_TXFULL = 1;
    localparam int CSU_ST_TXEMPTY = 2;
    localparam int CSU_ST_PAUSED = 3;
    localparam int CSU_ST_PERR = 4;
    localparam int CSU_ST_FERR = 5;
    localparam int CSU_ST_OVR = 6;
    localparam int CSU_ST_TXDROP = 7;
    localparam int CSU_ST_RXLVL = 8;
    localparam int CSU_ST_TXLVL = 16;

    // Control word: flow[10] baud[9:6] parity[5:4] dbits[3:2] stop[1:0].
    typedef struct packed {
        logic flow_en;
        logic [3:0] baud;
        logic [1:0] parity;
        logic [1:0] dbits;
        logic [1:0] stop;
    } csu_ctrl_t;
    localparam logic [10:0] CSU_CTRL_RST = 11'h14c; // 9600 8N1.
    localparam logic [1:0] CSU_STOP_1 = 2'h0;
    localparam logic [1:0] CSU_STOP_15 = 2'h1;
    localparam logic [1:0] CSU_PAR_NONE = 2'h0;
    localparam logic [1:0] CSU_PAR_ODD = 2'h1;

    typedef enum logic [2:0] {CSU_TX_IDLE, CSU_TX_START, CSU_TX_DATA,
        CSU_TX_PAR, CSU_TX_STOP} csu_tx_st_t;
    typedef enum logic [2:0] {CSU_RX_IDLE, CSU_RX_START, CSU_RX_DATA,
        CSU_RX_PAR, CSU_RX_STOP} csu_rx_st_t;

endpackage

/* hw/csu_fifo_if.sv */
// Valid/ready carrier between the serial port and one of its FIFOs.
`timescale 1ns/100ps
interface csu_fifo_if #(parameter int W = 8, parameter int AW = 6);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    logic [AW:0] level;

    modport store (input wr_valid, input wr_data, input rd_ready,
        output wr_ready, output rd_valid, output rd_data, output level);
    modport user (output wr_valid, output wr_data, output rd_ready,
        input wr_ready, input rd_valid, input rd_data, input level);
endinterface

/* hw/csu_fifo.sv */
// Show-ahead synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module csu_fifo
    import csu_pkg::*;
#(
    parameter int W = 8,
    parameter int DEPTH = 64,
    parameter int AW = 6
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Both FIFO sides.
    csu_fifo_if.store f
);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } csu_fifo_st_t;

    csu_fifo_st_t s_q, s_d;
    logic [W-1:0] mem [DEPTH];
    logic push, pop;

    // Full is honest: the writer is stalled once DEPTH words are held.
    assign f.wr_ready = s_q.cnt != (AW+1)'(DEPTH);
    assign f.rd_valid = s_q.cnt != '0;
    assign f.rd_data = mem[s_q.rp];
    assign f.level = s_q.cnt;
    assign push = f.wr_valid & f.wr_ready;
    assign pop = f.rd_ready & f.rd_valid;

    // Pointers wrap at DEPTH, which must be a power of two.
    always_comb
    begin
        s_d = s_q;
        if (push)
            s_d.wp = s_q.wp + 1'b1;
        if (pop)
            s_d.rp = s_q.rp + 1'b1;
        if (push & ~pop)
            s_d.cnt = s_q.cnt + 1'b1;
        else if (pop & ~push)
            s_d.cnt = s_q.cnt - 1'b1;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // Storage has no reset; only the pointers decide what is valid.
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[s_q.wp] <= f.wr_data;
    end
endmodule // csu_fifo

/* hw/csu_baud.sv */
// Oversampling tick generator for the standard bit rates.
`timescale 1ns/100ps
module csu_baud
    import csu_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Rate select and tick out.
    input wire logic [3:0] sel,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } csu_baud_st_t;

    csu_baud_st_t s_q, s_d;
    logic [15:0] div_tab [0:9];
    logic [15:0] div;

    // One divisor per supported rate, each a constant of the clock rate.
    for (genvar i = 0; i < 10; i++)
    begin : g_div
        assign div_tab[i] = 16'(CSU_CLK_HZ / (CSU_OVS * CSU_BAUD_RATE[i]));
    end

    // Codes beyond the table fall back to the default rate.
    assign div = (sel <= CSU_BAUD_MAX) ? div_tab[sel] : div_tab[CSU_BAUD_DEF];
    assign tick = s_q.tick;

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= div - 16'h0001)
        begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end
        else
            s_d.cnt = s_q.cnt + 16'h0001;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // Fastest rate still leaves over a hundred clocks between ticks.
    property p_tick_gap;
        @(posedge sys_clk) disable iff (!reset_n)
        s_q.tick |=> !s_q.tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("Bit-rate ticks came too close together.");
endmodule // csu_baud

/* tb/csu_cam_model.sv */
// Behavioural camera end of the serial control channel.
`timescale 1ns/100ps
module csu_cam_model
(
    // Clock.
    input wire logic sys_clk,
    // Serial lines seen from the camera.
    input wire logic txd,
    output logic rxd
);
    // ****************************************
    // Frame format, shared with the bench
    // ****************************************
    int nbits = 8;
    int par = 0;
    int stop_half = 2;
    int bitclk = 16 * 108;
    int n_bad = 0;
    logic [7:0] got_q[$];

    initial rxd = 1'b1;

    // Send one frame toward the port; the line idles high.
    task automatic send(input logic [7:0] c);
        int i;
        c = c & 8'((1 << nbits) - 1);
        @(posedge sys_clk);
        rxd <= 1'b0;
        repeat (bitclk) @(posedge sys_clk);
        for (i = 0; i < nbits + (par != 0); i++)
        begin
            rxd <= (i < nbits) ? c[i] : ^c ^ (par == 1);
            repeat (bitclk) @(posedge sys_clk);
        end
        rxd <= 1'b1;
        repeat (bitclk * stop_half / 2) @(posedge sys_clk);
    endtask

    // Decode frames from the port; checks land before a stop could end.
    always
    begin : rx_frame
        logic [7:0] c;
        int i;
        @(posedge sys_clk iff txd === 1'b0);
        c = 8'h00;
        repeat (bitclk / 2) @(posedge sys_clk);
        if (txd !== 1'b0) n_bad++;
        for (i = 0; i < nbits; i++)
        begin
            repeat (bitclk) @(posedge sys_clk);
            c[i] = txd;
        end
        if (par != 0)
        begin
            repeat (bitclk) @(posedge sys_clk);
            if (txd !== (^c ^ (par == 1))) n_bad++;
        end
        repeat (bitclk) @(posedge sys_clk);
        if (txd !== 1'b1) n_bad++;
        for (i = 2; i < stop_half; i++)
        begin
            repeat (bitclk * 2 / 5) @(posedge sys_clk);
            if (txd !== 1'b1) n_bad++;
        end
        got_q.push_back(c);
    end
endmodule // csu_cam_model

/* tb/csu_uart_bench.sv */
// Self-checking bench of the camera serial port.
`timescale 1ns/100ps
module csu_uart_bench
    import csu_pkg::*;
;
    // ****************************************
    // Stimulus and model state
    // ****************************************
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h1436f1e4;
    logic pready, pslverr, txd, rxd, e;
    logic [7:0] b, c, tx_q[$];
    int n_mismatch = 0, cmp_count = 0, k;

    always #2.5 sys_clk = ~sys_clk;

    csu_uart uut (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .txd(txd));
    csu_cam_model cam (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // One APB transfer; the wait is bounded so a dead slave cannot hang.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the release reach an edge before the next request is raised.
        @(posedge sys_clk);
    endtask

    // Compare the next frame seen by the camera with the model queue.
    task automatic chk_ser();
        int n;
        n = 0;
        while (cam.got_q.size() == 0 && n < 40000)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 40000) n_mismatch++;
        else chk_reg({24'h0, cam.got_q.pop_front()}, {24'h0, tx_q.pop_front()});
        chk_reg(32'(cam.n_bad), 32'h0);
    endtask

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin : main
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        apb(1'b0, CSU_ADDR_CTRL, 32'h0);
        chk_reg(r, 32'h14c);
        apb(1'b0, CSU_ADDR_STAT, 32'h0);
        chk_reg(r, 32'h4);
        apb(1'b0, 12'h00c, 32'h0);
        chk_reg({31'h0, e}, 32'h1);
        // Fastest rate, eight bits, even parity, two stops, both ways.
        apb(1'b1, CSU_ADDR_CTRL, 32'h26e);
        apb(1'b0, CSU_ADDR_CTRL, 32'h0);
        chk_reg(r, 32'h26e);
        cam.par = 2;
        cam.stop_half = 4;
        b = 8'(rnd());
        c = 8'(rnd());
        tx_q.push_back(b);
        apb(1'b1, CSU_ADDR_DATA, {24'h0, b});
        fork
            cam.send(c);
        join_none
        chk_ser();
        apb(1'b0, CSU_ADDR_DATA, 32'h0);
        chk_reg(r, {23'h0, 1'b1, c});
        // Six bits, odd parity, one and a half stops, flow control on.
        apb(1'b1, CSU_ADDR_CTRL, 32'h655);
        cam.nbits = 6;
        cam.par = 1;
        cam.stop_half = 3;
        cam.send(CSU_XOFF);
        apb(1'b0, CSU_ADDR_STAT, 32'h0);
        chk_reg(r, 32'hc);
        b = 8'(rnd()) & 8'h3f;
        tx_q.push_back(b);
        apb(1'b1, CSU_ADDR_DATA, {24'h0, b});
        repeat (3000) @(posedge sys_clk);
        chk_reg(32'(cam.got_q.size()), 32'h0);
        cam.send(CSU_XON);
        chk_ser();
        // One write goes straight to the shifter, then 64 fill the queue.
        repeat (4000) @(posedge sys_clk);
        for (k = 0; k < 66; k++) apb(1'b1, CSU_ADDR_DATA, rnd());
        apb(1'b0, CSU_ADDR_STAT, 32'h0);
        chk_reg(r, 32'h00400082);
        apb(1'b1, CSU_ADDR_STAT, 32'h80);
        apb(1'b0, CSU_ADDR_STAT, 32'h0);
        chk_reg(r, 32'h00400002);
        give_verdict();
    end

    // Cuts a hang short; the planned run needs about 73000 cycles.
    initial
    begin : watchdog
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        give_verdict();
    end
endmodule // csu_uart_bench
